//--- hdl/spi_cfg.svh
// Register map, reset values and timing counts of the serial engine
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH
`define SPI_DIV_ADDR    8'ha2
`define SPI_DATA_ADDR   8'ha3
`define SPI_DIV_RST     8'h00
`define SPI_DATA_RST    8'h00
`define SPI_WORD_W      8
`define SPI_FIFO_DEPTH  16
`define SPI_LAST_HALF   4'hf
`define SPI_LAST_BIT    3'h7
`define SPI_LATE_DLY    3'h4
`define SPI_LATE_FIRE   3'h1
`endif

//--- hdl/spi_pkg.sv
// Types shared by the serial engine
package spi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } master_state_t;
endpackage : spi_pkg

//--- hdl/spi_rx_fifo.sv
// Receive byte FIFO with valid and ready on both sides
module spi_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage has no reset; only pointers and count need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the power-of-two depth
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spi_rx_fifo

//--- hdl/spi_engine.sv
// Serial peripheral engine: clock divider, data register, master and slave link
`include "spi_cfg.svh"
module spi_engine (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Special function register port
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WE,
  input  wire logic       SFR_RE,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // Configuration levels
  input  wire logic       SPI_ENABLE,
  input  wire logic       MASTER_SELECT_BIT,
  input  wire logic       CLOCK_POLARITY_BIT,
  input  wire logic       CLOCK_PHASE_BIT,
  input  wire logic       INT_ENABLE,
  // Flags and their clear strobes
  input  wire logic       CLR_TRANSFER_COMPLETE,
  input  wire logic       CLR_WRITE_COLLISION,
  output logic            TRANSFER_COMPLETE_FLAG,
  output logic            WRITE_COLLISION_FLAG,
  output logic            TRANSMIT_BUFFER_EMPTY_FLAG,
  output logic            BUSY,
  output logic            IRQ,
  // Serial pins
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       NSS_I
);
  import spi_pkg::*;

  // Shift one received bit in at the bottom, MSB leaves first
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  logic sck_s1, sck_s2, sck_s3;
  logic mosi_s1, mosi_s2;
  logic miso_s1, miso_s2;
  logic nss_s1, nss_s2, nss_s3;

  // Two stages before any logic; third stage only for edges
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      {sck_s1, sck_s2, sck_s3}  <= 3'h0;
      {mosi_s1, mosi_s2}        <= 2'h0;
      {miso_s1, miso_s2}        <= 2'h0;
      {nss_s1, nss_s2, nss_s3}  <= 3'h7;
    end else begin
      {sck_s1, sck_s2, sck_s3}  <= {SCK_I, sck_s1, sck_s2};
      {mosi_s1, mosi_s2}        <= {MOSI_I, mosi_s1};
      {miso_s1, miso_s2}        <= {MISO_I, miso_s1};
      {nss_s1, nss_s2, nss_s3}  <= {NSS_I, nss_s1, nss_s2};
    end
  end

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  master_state_t state;
  master_state_t next_state;
  logic [7:0] divider;
  logic [7:0] txbuf;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] hc;
  logic [3:0] ec;
  logic [3:0] next_ec;
  logic [2:0] bc;
  logic [2:0] late;
  logic [7:0] last_rx;
  logic       m_fix;
  logic       m_done_q;
  logic       push_valid;
  logic [7:0] push_data;
  logic       fifo_ready;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  //--------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------
  wire is_master  = SPI_ENABLE && MASTER_SELECT_BIT;
  wire wr_div     = SFR_WE && SFR_ADDR == `SPI_DIV_ADDR;
  wire wr_data    = SFR_WE && SFR_ADDR == `SPI_DATA_ADDR;
  wire rd_data    = SFR_RE && SFR_ADDR == `SPI_DATA_ADDR;
  wire wr_ok      = wr_data && TRANSMIT_BUFFER_EMPTY_FLAG;
  wire wr_coll    = wr_data && !TRANSMIT_BUFFER_EMPTY_FLAG;
  wire pop        = rd_data && fifo_valid;

  // Master timing: half periods of divider+1 clocks
  // divider sets half period
  wire half_end   = hc == divider;
  // master sample in last clock of bit
  wire m_sample   = state == ST_RUN && half_end && ec[0];
  wire m_done     = m_sample && ec == `SPI_LAST_HALF;
  // start only when buffered; stalls while FIFO is full
  wire m_start    = state == ST_IDLE && is_master && !TRANSMIT_BUFFER_EMPTY_FLAG && fifo_ready;

  // Slave link; the master keeps setup and hold
  // slave path never looks at the divider
  wire sel        = SPI_ENABLE && !MASTER_SELECT_BIT && !nss_s2;
  wire nss_fall   = sel && nss_s3;
  wire sck_edge   = sck_s2 ^ sck_s3;
  wire lead       = sck_edge && (sck_s2 != CLOCK_POLARITY_BIT);
  wire trail      = sck_edge && (sck_s2 == CLOCK_POLARITY_BIT);
  // slave samples at mid-bit sampling edge
  wire s_sample   = sel && (CLOCK_PHASE_BIT ? trail : lead);
  wire s_shift    = sel && (CLOCK_PHASE_BIT ? lead : trail);
  wire s_done     = s_sample && bc == `SPI_LAST_BIT;
  wire done       = m_done || s_done;
  // buffer moves to shifter on start, select or byte end
  wire s_load     = (nss_fall || s_done) && !TRANSMIT_BUFFER_EMPTY_FLAG;
  wire load       = m_start || s_load;
  wire [7:0] rx_byte = shift_in(sh, is_master ? miso_s2 : mosi_s2);

  // Next shifter value; a load overrides the last shift
  // MSB first, eight bits
  always_comb begin
    next_sh = sh;
    if (m_sample || s_sample) begin
      next_sh = rx_byte;
    end
    // master bit lands a clock late, past the synchroniser
    if (m_fix) begin
      next_sh[0] = miso_s2;
    end
    if (load) begin
      next_sh = txbuf;
    end
  end

  // Master sequencing over sixteen half periods
  always_comb begin
    next_state = state;
    next_ec    = ec;
    if (m_start) begin
      next_state = ST_RUN;
      next_ec    = 4'h0;
    end else if (m_done || (state == ST_RUN && !is_master)) begin
      next_state = ST_IDLE;
    end else if (state == ST_RUN && half_end) begin
      next_ec    = ec + 4'h1;
    end
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  // Software visible registers and the transmit buffer
  // both read zero after reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      divider <= `SPI_DIV_RST;
      txbuf   <= `SPI_DATA_RST;
    end else begin
      divider <= wr_div ? SFR_WDATA : divider;
      // colliding write never reaches the buffer
      txbuf   <= wr_ok ? SFR_WDATA : txbuf;
    end
  end

  // Read data; the receive side is the FIFO head
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      SFR_RDATA <= 8'h00;
      last_rx   <= `SPI_DATA_RST;
    end else begin
      last_rx <= pop ? fifo_data : last_rx;
      if (SFR_RE) begin
        SFR_RDATA <= rd_data ? (fifo_valid ? fifo_data : last_rx) :
                     (SFR_ADDR == `SPI_DIV_ADDR) ? divider : 8'h00;
      end
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      TRANSFER_COMPLETE_FLAG     <= 1'b0;
      WRITE_COLLISION_FLAG       <= 1'b0;
      TRANSMIT_BUFFER_EMPTY_FLAG <= 1'b1;
      IRQ                        <= 1'b0;
      BUSY                       <= 1'b0;
    end else begin
      TRANSFER_COMPLETE_FLAG     <= done || (TRANSFER_COMPLETE_FLAG && !CLR_TRANSFER_COMPLETE);
      WRITE_COLLISION_FLAG       <= wr_coll || (WRITE_COLLISION_FLAG && !CLR_WRITE_COLLISION);
      // empty clears on write, sets on load
      TRANSMIT_BUFFER_EMPTY_FLAG <= load || (TRANSMIT_BUFFER_EMPTY_FLAG && !wr_ok);
      IRQ  <= INT_ENABLE && (done || (TRANSFER_COMPLETE_FLAG && !CLR_TRANSFER_COMPLETE));
      BUSY <= next_state == ST_RUN || (sel && (bc != 3'h0 || s_sample) && !s_done);
    end
  end

  // Shifter, counters and the received byte hand-off
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state      <= ST_IDLE;
      sh         <= 8'h00;
      hc         <= 8'h00;
      ec         <= 4'h0;
      bc         <= 3'h0;
      late       <= 3'h0;
      push_valid <= 1'b0;
      push_data  <= 8'h00;
      m_fix      <= 1'b0;
      m_done_q   <= 1'b0;
    end else begin
      state      <= next_state;
      sh         <= next_sh;
      ec         <= next_ec;
      hc         <= (m_start || half_end) ? 8'h00 : hc + 8'h01;
      bc         <= !sel ? 3'h0 : s_sample ? bc + 3'h1 : bc;
      // phase-one slave waits before presenting next byte
      late       <= (s_done && CLOCK_PHASE_BIT) ? `SPI_LATE_DLY :
                    (late != 3'h0) ? late - 3'h1 : late;
      // received byte goes to the receive buffer
      // Master byte waits one clock so its last bit clears the synchroniser
      m_fix      <= m_sample;
      m_done_q   <= m_done;
      push_valid <= s_done || m_done_q;
      push_data  <= m_done_q ? {sh[7:1], miso_s2} : rx_byte;
    end
  end

  //--------------------------------------------------------------
  // Pin drivers
  //--------------------------------------------------------------
  // Master pins; SCK idles at the polarity level
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      SCK_O   <= 1'b0;
      SCK_OE  <= 1'b0;
      MOSI_O  <= 1'b0;
      MOSI_OE <= 1'b0;
    end else begin
      SCK_OE  <= is_master;
      MOSI_OE <= is_master;
      SCK_O   <= (next_state == ST_RUN) ?
                 (CLOCK_POLARITY_BIT ^ CLOCK_PHASE_BIT ^ next_ec[0]) : CLOCK_POLARITY_BIT;
      // data leaves on start and after each sample
      MOSI_O  <= (m_start || m_sample) ? next_sh[7] : MOSI_O;
    end
  end

  // Slave MISO; drive follows the synchronised select
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      MISO_O  <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      // drive on select; release on deselect
      MISO_OE <= sel;
      if (nss_fall && !CLOCK_PHASE_BIT) begin
        // first bit ready before first edge
        MISO_O <= next_sh[7];
      end else if (s_shift) begin
        MISO_O <= sh[7];
      end else if (late == `SPI_LATE_FIRE) begin
        MISO_O <= sh[7];
      end
    end
  end

  //--------------------------------------------------------------
  // Receive FIFO
  //--------------------------------------------------------------
  spi_rx_fifo #(
    .WIDTH (`SPI_WORD_W),
    .DEPTH (`SPI_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (CLK),
    .rstn      (RSTN),
    .in_valid  (push_valid),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );
endmodule : spi_engine

//--- verif/spi_engine_properties.sv
// Port checks on the serial engine, bound beside it
`include "spi_cfg.svh"
module spi_engine_checker (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WE,
  input wire logic [7:0] SFR_WDATA,
  // Mode levels and clear
  input wire logic       SPI_ENABLE,
  input wire logic       MASTER_SELECT_BIT,
  input wire logic       CLOCK_POLARITY_BIT,
  input wire logic       CLR_TRANSFER_COMPLETE,
  // Engine outputs and select
  input wire logic       TRANSFER_COMPLETE_FLAG,
  input wire logic       WRITE_COLLISION_FLAG,
  input wire logic       TRANSMIT_BUFFER_EMPTY_FLAG,
  input wire logic       BUSY,
  input wire logic       SCK_O,
  input wire logic       SCK_OE,
  input wire logic       MISO_OE,
  input wire logic       NSS_I
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Helper state
  // ----------------
  logic [7:0] div;
  logic [8:0] run;
  logic       last_sck;
  logic       seen;
  wire        flip   = SCK_O != last_sck;
  wire        dat_wr = SFR_WE && SFR_ADDR == `SPI_DATA_ADDR;
  wire        mst    = SPI_ENABLE && MASTER_SELECT_BIT;
  // Divider shadow; run counts cycles since the last clock flip
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      div      <= `SPI_DIV_RST;
      run      <= 9'h000;
      last_sck <= 1'b0;
      seen     <= 1'b0;
    end else begin
      if (SFR_WE && SFR_ADDR == `SPI_DIV_ADDR)
        div <= SFR_WDATA;
      run      <= flip ? 9'h000 : run + 9'h001;
      last_sck <= SCK_O;
      seen     <= BUSY && (seen || flip);
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // First flip after idle is skipped: its idle stretch has no fixed length
  AST_HALF_LEN: assert property (flip && seen && BUSY && SCK_OE |-> run == {1'b0, div})
    else $error("half period differs from divider plus one");
  AST_OE_MODE: assert property ($past(RSTN) |-> SCK_OE == $past(mst))
    else $error("clock drive does not follow master mode");
  AST_IDLE_POL: assert property ($past(RSTN) && SCK_OE && !BUSY && !$past(BUSY) && $stable(CLOCK_POLARITY_BIT)
    |-> SCK_O == CLOCK_POLARITY_BIT)
    else $error("idle clock level differs from polarity");
  AST_TXE_CLR: assert property (dat_wr && TRANSMIT_BUFFER_EMPTY_FLAG |=> !TRANSMIT_BUFFER_EMPTY_FLAG)
    else $error("buffer empty flag not cleared by write");
  AST_WRITE_COLLISION_FLAG_SET: assert property (dat_wr && !TRANSMIT_BUFFER_EMPTY_FLAG |=> WRITE_COLLISION_FLAG)
    else $error("collision flag not set");
  AST_TC_HOLD: assert property (TRANSFER_COMPLETE_FLAG && !CLR_TRANSFER_COMPLETE |=> TRANSFER_COMPLETE_FLAG)
    else $error("complete flag dropped without clear");
  AST_SEL_MISO: assert property ($fell(NSS_I) && SPI_ENABLE && !MASTER_SELECT_BIT |-> ##[1:4] MISO_OE)
    else $error("slave output not driven after select");
  AST_DESEL_MISO: assert property ($rose(NSS_I) && !MASTER_SELECT_BIT |-> ##[1:4] !MISO_OE)
    else $error("slave output not released after deselect");
  // Main scenarios reached
  cover property ($rose(TRANSFER_COMPLETE_FLAG));
  cover property ($rose(WRITE_COLLISION_FLAG));
  cover property ($rose(MISO_OE));
endmodule : spi_engine_checker

bind spi_engine spi_engine_checker chk (.*);

//--- verif/spi_far_end.sv
// Far-side model: slave to the engine's master, or master by task
module spi_far_end (
  // Clock
  input  wire logic clk,
  // Mode and polarity
  input  wire logic pol,
  input  wire logic slave_role,
  // Wire levels seen
  input  wire logic sck_w,
  input  wire logic mosi_w,
  input  wire logic miso_w,
  // Driven pins
  output logic      sck,
  output logic      mosi,
  output logic      miso,
  output logic      miso_oe,
  output logic      nss
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Shift state
  // ----------------
  logic [7:0] sh  = 8'h00;
  logic       bin = 1'b0;
  initial sck  = 1'b0;
  initial mosi = 1'b0;
  initial nss  = 1'b1;
  assign miso    = sh[7];
  assign miso_oe = slave_role;
  // sample on leading edge, shift on trailing edge
  always @(sck_w) begin
    if (slave_role && sck_w != pol)
      bin = mosi_w;
    else if (slave_role)
      sh = {sh[6:0], bin};
  end
  // six clocks a half bit keeps every margin
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    sck <= pol;
    repeat (4) @(posedge clk);
    nss  <= 1'b0;
    mosi <= tx[7];
    for (int i = 7; i >= 0; i--) begin
      repeat (6) @(posedge clk);
      sck   <= ~pol;
      rx[i] = miso_w;
      repeat (6) @(posedge clk);
      sck   <= pol;
      mosi  <= tx[(i + 7) % 8];
    end
    repeat (3) @(posedge clk);
    nss <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : spi_far_end

//--- verif/test_spi_engine.sv
// Self-checking bench for the serial engine
`include "spi_cfg.svh"
module test_spi_engine;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Pins and state
  // ----------------
  logic       CLK = 1'b0;
  logic       RSTN = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic       SFR_WE = 1'b0;
  logic       SFR_RE = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  logic       SPI_ENABLE = 1'b1;
  logic       MASTER_SELECT_BIT = 1'b1;
  logic       CLOCK_POLARITY_BIT = 1'b0;
  logic       CLOCK_PHASE_BIT = 1'b0;
  logic       INT_ENABLE = 1'b0;
  logic       CLR_TRANSFER_COMPLETE = 1'b0;
  logic       CLR_WRITE_COLLISION = 1'b0;
  logic [7:0] SFR_RDATA;
  logic       TRANSFER_COMPLETE_FLAG, WRITE_COLLISION_FLAG, TRANSMIT_BUFFER_EMPTY_FLAG, BUSY, IRQ;
  logic       SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
  wire logic  SCK_I, MOSI_I, MISO_I, NSS_I;
  logic       f_sck, f_mosi, f_miso, f_oe;
  logic       last_miso = 1'b0;
  int         errors = 0;
  int         n_checks = 0;
  logic [7:0] got, rxb;
  logic [7:0] cfg [4] = '{8'h00, 8'h03, 8'hff, 8'h01};
  // Released MISO shows the inverse of its last level, never a stale one
  assign SCK_I  = SCK_OE ? SCK_O : f_sck;
  assign MOSI_I = MOSI_OE ? MOSI_O : f_mosi;
  assign MISO_I = MISO_OE ? MISO_O : (f_oe ? f_miso : ~last_miso);
  always @(posedge CLK) last_miso <= MISO_I;
  always #25 CLK = ~CLK;
  spi_engine DUT (.*);
  spi_far_end far (.clk(CLK), .pol(CLOCK_POLARITY_BIT), .slave_role(MASTER_SELECT_BIT), .sck_w(SCK_I),
    .mosi_w(MOSI_I), .miso_w(MISO_I), .sck(f_sck), .mosi(f_mosi), .miso(f_miso), .miso_oe(f_oe), .nss(NSS_I));
  // Register port cycles and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    SFR_ADDR  <= a;
    SFR_WDATA <= d;
    SFR_WE    <= 1'b1;
    @(posedge CLK);
    SFR_WE    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    SFR_ADDR <= a;
    SFR_RE   <= 1'b1;
    @(posedge CLK);
    SFR_RE   <= 1'b0;
    #1 d = SFR_RDATA;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim();
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Wait for completion, then see it stick and clear
  task automatic wait_tc();
    for (int i = 0; i < 5000 && TRANSFER_COMPLETE_FLAG !== 1'b1; i++) @(posedge CLK);
    repeat (3) @(posedge CLK);
    chk(TRANSFER_COMPLETE_FLAG, 1'b1);
    chk(IRQ, INT_ENABLE);
    CLR_TRANSFER_COMPLETE <= 1'b1;
    @(posedge CLK);
    CLR_TRANSFER_COMPLETE <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk(TRANSFER_COMPLETE_FLAG, 1'b0);
  endtask : wait_tc
  // Watchdog sized well above the longest sequence
  initial begin
    repeat (40000) @(posedge CLK);
    errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(`SPI_DIV_ADDR, got);
    chk(got, `SPI_DIV_RST);
    rd(`SPI_DATA_ADDR, got);
    chk(got, `SPI_DATA_RST);
    rd(8'h55, got);
    chk(got, 8'h00);
    // Master frames over divider and polarity corners
    for (int k = 0; k < 4; k++) begin
      CLOCK_POLARITY_BIT <= k[0];
      INT_ENABLE         <= k[1];
      repeat (4) @(posedge CLK);
      chk(SCK_O, k[0]);
      far.sh = 8'h5a ^ k[7:0];
      wr(`SPI_DIV_ADDR, cfg[k]);
      wr(`SPI_DATA_ADDR, 8'hc3 + k[7:0]);
      wait_tc();
      chk(far.sh, 8'hc3 + k[7:0]);
      rd(`SPI_DATA_ADDR, got);
      chk(got, 8'h5a ^ k[7:0]);
    end
    rd(`SPI_DIV_ADDR, got);
    chk(got, 8'h01);
    // Slave: divider ignored, second write dropped and flagged
    MASTER_SELECT_BIT <= 1'b0;
    wr(`SPI_DIV_ADDR, 8'h07);
    #1 chk(SCK_OE, 1'b0);
    wr(`SPI_DATA_ADDR, 8'ha5);
    #1 chk(TRANSMIT_BUFFER_EMPTY_FLAG, 1'b0);
    wr(`SPI_DATA_ADDR, 8'h3c);
    repeat (2) @(posedge CLK);
    #1 chk(WRITE_COLLISION_FLAG, 1'b1);
    CLR_WRITE_COLLISION <= 1'b1;
    @(posedge CLK);
    CLR_WRITE_COLLISION <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk(WRITE_COLLISION_FLAG, 1'b0);
    // Seventeen frames overfill the receive FIFO; empty buffer echoes the last byte read from it
    for (int k = 0; k < 17; k++) begin
      far.xfer(8'h10 + k[7:0], rxb);
      chk(rxb, (k == 0) ? 8'ha5 : 8'h0f + k[7:0]);
    end
    for (int k = 0; k < 17; k++) begin
      rd(`SPI_DATA_ADDR, got);
      chk(got, 8'h10 + ((k < 16) ? k[7:0] : 8'h0f));
    end
    end_sim();
  end
endmodule : test_spi_engine
